// File: fwcp_sync.sv
package fwcp_pkg;
   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int          CLK_MHZ     = 50;
   localparam int          STBY_NS     = 1000;
   localparam int          STBY_CYC_I  = (STBY_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0]  STBY_CYC    = 8'(STBY_CYC_I);
   localparam int          SYNC_W      = 4;
   // ****************************************************************
   // Frame layout and reset values
   // ****************************************************************
   localparam logic [2:0]  BIT_LAST    = 3'h7;
   localparam logic [2:0]  CNT_RST     = 3'h0;
   localparam logic [1:0]  DIV_RST     = 2'h0;
   localparam logic [1:0]  DIV4_LAST   = 2'h3;
   localparam logic [7:0]  RST_CNT_RST = 8'h00;
   localparam int          SYNC_PCLK   = 0;
   localparam int          SYNC_SEL    = 1;
   localparam int          SYNC_DIR    = 2;
   localparam int          SYNC_SDL    = 3;
   localparam logic [3:0]  SYNC_RST    = 4'h2;

   typedef enum logic [3:0] {
      FWCP_IDLE = 4'h1,
      FWCP_ADDR = 4'h2,
      FWCP_DATA = 4'h4,
      FWCP_DONE = 4'h8
   } fwcp_fsm_t;

   typedef struct packed {
      logic [127:0][7:0] regs;
      fwcp_fsm_t         fsm;
      logic [2:0]        cnt;
      logic [7:0]        addr;
      logic [7:0]        wdata;
      logic [7:0]        rshift;
      logic              oe;
      logic              pclk_prev;
      logic              wr_pulse;
      logic [6:0]        wr_idx;
      logic [7:0]        wr_data;
      logic              txrx_en;
      logic [7:0]        rst_cnt;
      logic              standby;
      logic [1:0]        div_cnt;
      logic              div2;
      logic              div4;
   } fwcp_state_t;
endpackage : fwcp_pkg

`timescale 1ns/10ps
`default_nettype none
module fwcp_sync #(
   parameter int                W   = 1,
   parameter logic [W-1:0]      RST = '0
) (
   input  wire logic            mclk,
   input  wire logic            resetn,
   input  wire logic            clk_en,
   input  wire logic [W-1:0]    d_in,
   output logic      [W-1:0]    d_out
);
   // ****************************************************************
   // Two-stage synchroniser
   // ****************************************************************
   logic [W-1:0] meta_q;

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         meta_q <= RST;
         d_out  <= RST;
      end else if (clk_en) begin
         meta_q <= d_in;
         d_out  <= meta_q;
      end
   end
endmodule : fwcp_sync
`default_nettype wire

// File: fwcp_port.sv
// Summary of operation
// - Every eight-bit word on the serial data line travels most significant bit first.
// - A transfer is an eight-bit register address followed directly by eight data bits.
// - The data line driver stays off and drives only while the select and read direction hold.
// - Serial data is clocked on the rising edge of the controller's port clock.
// - The port acts only while select is low and ignores data, clock and direction otherwise.
// - The select touches nothing of the transmit or receive ports.
// - Master reset disables transmit and receive, and a long reset enters power standby.
// - Master reset leaves all configuration registers unchanged, so software programs them.
// - Internal clocks come from the master clock divided by two or by four.
// - Deasserting the select resets the shift state machine and drops a partial transfer.
// - The lowest address bit is ignored when choosing the register.
// - The rising port clock edge samples address and write data and launches read data bits.
`timescale 1ns/10ps
`default_nettype none
module fwcp_port (
   input  wire logic        mclk,
   input  wire logic        resetn,
   input  wire logic        clk_en,
   input  wire logic        port_clk,
   input  wire logic        sel_n,
   input  wire logic        dir_rd,
   input  wire logic        sdl_in,
   output logic             sdl_out,
   output logic             sdl_oe,
   output logic             cfg_wr_pulse,
   output logic [6:0]       cfg_wr_idx,
   output logic [7:0]       cfg_wr_data,
   output logic             txrx_en,
   output logic             standby,
   output logic             div2_tick,
   output logic             div4_tick
);
   // ****************************************************************
   // Input synchronisation
   // ****************************************************************
   // The port clock is only sampled; four master cycles per port clock level leave margin.
   logic [fwcp_pkg::SYNC_W-1:0] pins_s;
   logic                        pclk_s;
   logic                        sel_s_n;
   logic                        dir_s;
   logic                        sdl_s;
   logic                        rising;
   fwcp_pkg::fwcp_state_t       st_q;
   fwcp_pkg::fwcp_state_t       st_d;

   fwcp_sync #(
      .W   (fwcp_pkg::SYNC_W),
      .RST (fwcp_pkg::SYNC_RST)
   ) u_sync (
      .mclk   (mclk),
      .resetn (resetn),
      .clk_en (clk_en),
      .d_in   ({sdl_in, dir_rd, sel_n, port_clk}),
      .d_out  (pins_s)
   );

   assign pclk_s  = pins_s[fwcp_pkg::SYNC_PCLK];
   assign sel_s_n = pins_s[fwcp_pkg::SYNC_SEL];
   assign dir_s   = pins_s[fwcp_pkg::SYNC_DIR];
   assign sdl_s   = pins_s[fwcp_pkg::SYNC_SDL];
   assign rising  = pclk_s & ~st_q.pclk_prev;

   function automatic logic [6:0] reg_index(input logic [7:0] a);
      reg_index = a[7:1];
   endfunction : reg_index

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      st_d           = st_q;
      st_d.wr_pulse  = 1'b0;
      st_d.pclk_prev = pclk_s;
      st_d.txrx_en   = 1'b1;
      st_d.standby   = 1'b0;
      st_d.rst_cnt   = fwcp_pkg::RST_CNT_RST;
      st_d.div_cnt   = st_q.div_cnt + 2'h1;
      st_d.div2      = st_q.div_cnt[0];
      st_d.div4      = (st_q.div_cnt == fwcp_pkg::DIV4_LAST);
      if (sel_s_n) begin
         // Deselect abandons any partial frame and releases the line.
         st_d.fsm = fwcp_pkg::FWCP_IDLE;
         st_d.cnt = fwcp_pkg::CNT_RST;
         st_d.oe  = 1'b0;
      end else begin
         st_d.oe = dir_s;
         if (rising) begin
            case (st_q.fsm)
               fwcp_pkg::FWCP_IDLE, fwcp_pkg::FWCP_ADDR: begin
                  st_d.addr = {st_q.addr[6:0], sdl_s};
                  st_d.cnt  = st_q.cnt + 3'h1;
                  st_d.fsm  = fwcp_pkg::FWCP_ADDR;
                  if (st_q.cnt == fwcp_pkg::BIT_LAST) begin
                     // The address low bit is already irrelevant, so the read word loads now.
                     st_d.fsm    = fwcp_pkg::FWCP_DATA;
                     st_d.cnt    = fwcp_pkg::CNT_RST;
                     st_d.rshift = st_q.regs[reg_index(st_d.addr)];
                  end
               end
               fwcp_pkg::FWCP_DATA: begin
                  st_d.wdata  = {st_q.wdata[6:0], sdl_s};
                  st_d.rshift = {st_q.rshift[6:0], 1'b0};
                  st_d.cnt    = st_q.cnt + 3'h1;
                  if (st_q.cnt == fwcp_pkg::BIT_LAST) begin
                     st_d.fsm = fwcp_pkg::FWCP_DONE;
                     if (!dir_s) begin
                        st_d.regs[reg_index(st_q.addr)] = st_d.wdata;
                        st_d.wr_pulse = 1'b1;
                        st_d.wr_idx   = reg_index(st_q.addr);
                        st_d.wr_data  = st_d.wdata;
                     end
                  end
               end
               fwcp_pkg::FWCP_DONE: begin
                  st_d.fsm = fwcp_pkg::FWCP_DONE;
               end
               default: begin
                  st_d.fsm = fwcp_pkg::FWCP_IDLE;
               end
            endcase
         end
      end
      if (!resetn) begin
         // Registers are deliberately kept: software must reprogram after power-up.
         st_d.fsm       = fwcp_pkg::FWCP_IDLE;
         st_d.cnt       = fwcp_pkg::CNT_RST;
         st_d.addr      = 8'h00;
         st_d.wdata     = 8'h00;
         st_d.rshift    = 8'h00;
         st_d.oe        = 1'b0;
         st_d.wr_pulse  = 1'b0;
         st_d.wr_idx    = 7'h00;
         st_d.wr_data   = 8'h00;
         st_d.txrx_en   = 1'b0;
         st_d.div_cnt   = fwcp_pkg::DIV_RST;
         st_d.div2      = 1'b0;
         st_d.div4      = 1'b0;
         st_d.rst_cnt   = (st_q.rst_cnt == fwcp_pkg::STBY_CYC) ? st_q.rst_cnt
                                                               : st_q.rst_cnt + 8'h01;
         st_d.standby   = (st_q.rst_cnt == fwcp_pkg::STBY_CYC);
      end
   end

   always_ff @(posedge mclk) begin
      if (clk_en || !resetn) begin
         st_q <= st_d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   // Of these, txrx_en does not depend on the select, so transmit and receive are untouched by it.
   assign sdl_out      = st_q.rshift[7];
   assign sdl_oe       = st_q.oe;
   assign cfg_wr_pulse = st_q.wr_pulse;
   assign cfg_wr_idx   = st_q.wr_idx;
   assign cfg_wr_data  = st_q.wr_data;
   assign txrx_en      = st_q.txrx_en;
   assign standby      = st_q.standby;
   assign div2_tick    = st_q.div2;
   assign div4_tick    = st_q.div4;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   property p_oe_needs_read;
      sdl_oe |-> $past(dir_s) && !$past(sel_s_n);
   endproperty
   a_oe_needs_read: assert property (p_oe_needs_read) else $error("Line driven without read.");

   property p_deselect_idle;
      $past(sel_s_n) && $past(clk_en) && $past(resetn) |->
         st_q.fsm == fwcp_pkg::FWCP_IDLE && !sdl_oe;
   endproperty
   a_deselect_idle: assert property (p_deselect_idle) else $error("Deselect left state.");

   property p_count_on_rise;
      $past(resetn) && st_q.cnt != $past(st_q.cnt) && !$past(sel_s_n) |-> $past(rising);
   endproperty
   a_count_on_rise: assert property (p_count_on_rise) else $error("Shift without rise.");

   property p_addr_eight;
      st_q.fsm == fwcp_pkg::FWCP_DATA && $past(st_q.fsm) == fwcp_pkg::FWCP_ADDR |->
         $past(st_q.cnt) == 3'h7 && st_q.cnt == 3'h0;
   endproperty
   a_addr_eight: assert property (p_addr_eight) else $error("Address not eight bits.");

   property p_write_lands;
      cfg_wr_pulse |-> st_q.fsm == fwcp_pkg::FWCP_DONE &&
         st_q.regs[cfg_wr_idx] == cfg_wr_data && cfg_wr_idx == st_q.addr[7:1];
   endproperty
   a_write_lands: assert property (p_write_lands) else $error("Write misplaced.");

   property p_read_msb;
      // Only reads are judged, since a write may pass over a register never loaded.
      sdl_oe && st_q.fsm == fwcp_pkg::FWCP_DATA && st_q.cnt == 3'h0 |->
         sdl_out == st_q.regs[reg_index(st_q.addr)][7];
   endproperty
   a_read_msb: assert property (p_read_msb) else $error("Read word not MSB first.");

   property p_reset_disables;
      @(posedge mclk) disable iff (1'b0)
         !resetn |=> !txrx_en && !sdl_oe && !cfg_wr_pulse;
   endproperty
   a_reset_disables: assert property (p_reset_disables) else $error("Reset left port on.");

   property p_div_ratio;
      div4_tick && clk_en |-> div2_tick ##1 !div4_tick;
   endproperty
   a_div_ratio: assert property (p_div_ratio) else $error("Divider ratio wrong.");

endmodule : fwcp_port
`default_nettype wire

// File: fwcp_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Controller model on the far side of the serial port
// ****************************************************************
module fwcp_ctrl_model (
   input  wire logic mclk,
   input  wire logic sdl_out,
   input  wire logic sdl_oe,
   output logic      port_clk,
   output logic      sel_n,
   output logic      dir_rd,
   output logic      sdl_in
);
   logic drv;
   logic bit_q;
   logic last;
   // The three-wire data input is a plain output port, not an inout, so it cannot float here.
   initial begin
      port_clk = 1'b0;
      sel_n    = 1'b1;
      dir_rd   = 1'b0;
      drv      = 1'b1;
      bit_q    = 1'b0;
      last     = 1'b0;
   end
   // An undriven line shows a changing level, never a held copy of the last bit.
   always_comb sdl_in = sdl_oe ? sdl_out : (drv ? bit_q : ~last);
   always @(posedge mclk) last <= sdl_in;
   // Four master cycles per level keeps the port clock under the limit.
   task automatic hold4();
      repeat (4) @(posedge mclk);
      #2;
   endtask : hold4
   task automatic xfer(input logic [7:0] a, input logic [7:0] d, input bit rd,
                       input int nbits, output logic [7:0] q);
      q     = 8'h00;
      sel_n = 1'b0;
      hold4();
      for (int i = 0; i < nbits; i++) begin
         // Direction turns before the rise that launches read data.
         if (rd && i == 7) begin
            dir_rd = 1'b1;
            drv    = 1'b0;
         end
         bit_q = (i < 8) ? a[7 - i] : ((i < 16) ? d[15 - i] : 1'b0);
         hold4();
         port_clk = 1'b1;
         hold4();
         if (rd && i >= 7 && i < 15) q[14 - i] = sdl_in;
         port_clk = 1'b0;
      end
      hold4();
      sel_n  = 1'b1;
      dir_rd = 1'b0;
      drv    = 1'b1;
      hold4();
   endtask : xfer
   task automatic idle_clocks(input int n, output int oe_seen);
      oe_seen = 0;
      dir_rd  = 1'b1;
      for (int i = 0; i < n; i++) begin
         bit_q    = i[0];
         port_clk = ~port_clk;
         hold4();
         oe_seen += (sdl_oe !== 1'b0);
      end
      port_clk = 1'b0;
      dir_rd   = 1'b0;
      hold4();
   endtask : idle_clocks
endmodule : fwcp_ctrl_model
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic       mclk, resetn, port_clk, sel_n, dir_rd, sdl_in, sdl_out, sdl_oe;
   logic       cfg_wr_pulse, txrx_en, standby, div2_tick, div4_tick, clk_en;
   logic [6:0] cfg_wr_idx;
   logic [7:0] cfg_wr_data, q;
   logic [7:0] ta [4] = '{8'h00, 8'h24, 8'hfe, 8'h81};
   logic [7:0] td [4] = '{8'h5a, 8'ha5, 8'hff, 8'h01};
   int         fails = 0, samples_checked = 0, pulses = 0, drops = 0, p0, n2, n4;
   fwcp_port DUT (.mclk(mclk), .resetn(resetn), .clk_en(clk_en), .port_clk(port_clk),
      .sel_n(sel_n), .dir_rd(dir_rd), .sdl_in(sdl_in), .sdl_out(sdl_out), .sdl_oe(sdl_oe),
      .cfg_wr_pulse(cfg_wr_pulse), .cfg_wr_idx(cfg_wr_idx), .cfg_wr_data(cfg_wr_data),
      .txrx_en(txrx_en), .standby(standby), .div2_tick(div2_tick), .div4_tick(div4_tick));
   fwcp_ctrl_model u_ctrl (.mclk(mclk), .sdl_out(sdl_out), .sdl_oe(sdl_oe),
      .port_clk(port_clk), .sel_n(sel_n), .dir_rd(dir_rd), .sdl_in(sdl_in));
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   always @(posedge mclk) if (cfg_wr_pulse === 1'b1) pulses <= pulses + 1;
   always @(posedge mclk) if (sel_n === 1'b0 && txrx_en !== 1'b1) drops <= drops + 1;
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: %s seen %h wanted %h", $time, what, seen, exp);
      end
   endtask : check
   task automatic summarize();
      $display("checked %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : summarize
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_write_read();
      for (int k = 0; k < 4; k++) begin
         p0 = pulses;
         u_ctrl.xfer(ta[k], td[k], 1'b0, 16, q);
         check(8'(pulses - p0), 8'h01, "write pulse");
         check({1'b0, cfg_wr_idx}, {1'b0, ta[k][7:1]}, "write index");
         check(cfg_wr_data, td[k], "write data");
      end
      for (int k = 0; k < 4; k++) begin
         u_ctrl.xfer(ta[k] ^ 8'h01, 8'h00, 1'b1, 16, q);
         check(q, td[k], "read back");
      end
      check(8'(drops), 8'h00, "txrx under select");
      $display("write/read test done");
   endtask : t_write_read
   task automatic t_abort();
      p0 = pulses;
      u_ctrl.xfer(8'h24, 8'h3c, 1'b0, 12, q);
      check(8'(pulses - p0), 8'h00, "partial frame wrote");
      u_ctrl.xfer(8'h24, 8'h00, 1'b1, 16, q);
      check(q, 8'ha5, "after abort");
      u_ctrl.idle_clocks(40, n2);
      check(8'(pulses - p0), 8'h00, "deselected write");
      check(8'(n2), 8'h00, "drive while deselected");
      p0 = pulses;
      u_ctrl.xfer(8'h42, 8'h3c, 1'b0, 18, q);
      check(8'(pulses - p0), 8'h01, "extra rises wrote");
      check(cfg_wr_data, 8'h3c, "extra rises data");
      $display("abort/deselect test done");
   endtask : t_abort
   task automatic t_reset();
      resetn = 1'b0;
      repeat (60) @(posedge mclk);
      #2;
      check({7'h0, txrx_en}, 8'h00, "txrx in reset");
      check({7'h0, standby}, 8'h01, "standby");
      resetn = 1'b1;
      repeat (4) @(posedge mclk);
      #2;
      check({7'h0, txrx_en}, 8'h01, "txrx after reset");
      check({7'h0, standby}, 8'h00, "standby after reset");
      n2 = 0;
      n4 = 0;
      repeat (8) begin
         @(posedge mclk);
         #2;
         n2 += (div2_tick === 1'b1);
         n4 += (div4_tick === 1'b1);
      end
      check(8'(n2), 8'h04, "half rate ticks");
      check(8'(n4), 8'h02, "quarter rate ticks");
      // Reading back only after reset is released.
      u_ctrl.xfer(8'hfe, 8'h00, 1'b1, 16, q);
      check(q, 8'hff, "kept over reset");
      $display("reset test done");
   endtask : t_reset
   task automatic t_freeze();
      logic [1:0] held;
      held   = {div2_tick, div4_tick};
      clk_en = 1'b0;
      n2     = 0;
      repeat (6) begin
         @(posedge mclk);
         #2;
         n2 += ({div2_tick, div4_tick} !== held);
      end
      clk_en = 1'b1;
      @(posedge mclk);
      #2;
      check(8'(n2), 8'h00, "ticks while frozen");
      check({7'h0, div2_tick}, {7'h0, ~held[1]}, "half rate resumes");
      $display("clock enable test done");
   endtask : t_freeze
   initial begin
      clk_en = 1'b1;
      resetn = 1'b0;
      repeat (3) @(posedge mclk);
      #2;
      resetn = 1'b1;
      repeat (4) @(posedge mclk);
      #2;
      t_write_read();
      t_abort();
      t_reset();
      t_freeze();
      summarize();
   end
   initial begin
      repeat (20000) @(posedge mclk);
      fails++;
      summarize();
   end
endmodule : tb_top
`default_nettype wire
